// ---- battery_status_flag_logic.sv ----
// status and alarm flags of the pack status word
`include "battery_status_regs.svh"
`default_nettype none
module battery_status_flag_logic #(
  parameter int unsigned OC_RECOVER_CYCLES = `OC_RECOVER_CYCLES,
  parameter int unsigned BROADCAST_CYCLES  = `BROADCAST_CYCLES
) (
  // clock, reset, enable
  input  wire logic                         sys_clk,
  input  wire logic                         rst_b,
  input  wire logic                         clkEn,
  // gauge quantities, same clock domain
  input  wire logic [15:0]                  capacity_left,
  input  wire logic [15:0]                  capacity_when_full,
  input  wire logic [7:0]                   charge_percent,
  input  wire logic [15:0]                  capacity_threshold,
  input  wire logic [15:0]                  runtime_left,
  input  wire logic [15:0]                  runtime_threshold,
  input  wire logic [15:0]                  maxCellMv,
  input  wire logic [15:0]                  minCellMv,
  input  wire logic [15:0]                  chargeMa,
  input  wire logic [15:0]                  dischargeMa,
  input  wire logic [15:0]                  dischargedMahDelta,
  input  wire logic [7:0]                   tempC,
  input  wire logic                         chargeMode,
  input  wire logic                         chargeTermination,
  input  wire logic                         gaugeInitDone,
  // command port of the bus engine
  input  wire logic                         cmdRead,
  input  wire logic [7:0]                   cmdCode,
  output logic                              readValid,
  output logic [15:0]                       readData,
  // broadcast request to the bus master engine
  output logic                              broadcastReq,
  input  wire logic                         broadcastAck,
  output logic [7:0]                        broadcastCmd,
  output battery_status_pkg::word_type      alarm_broadcast_word,
  // protection switch controls
  output logic                              chargeSwitchOff,
  output logic                              dischargeSwitchOff,
  // the status word itself
  output battery_status_pkg::word_type      pack_status_word
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic overcharge_alarm;
  logic charge_stop_alarm;
  logic discharge_stop_alarm;
  logic overTempAlarm;
  logic capAlarm;
  logic timeAlarm;
  logic full_flag;
  logic empty_flag;
  logic discharging;
  logic gauge_ready_flag;
  logic [16:0] dischargedSum;
  logic [31:0] broadcastTimer;
  battery_status_pkg::overtemp_type otCause;

  // fault causes latched for bits 14 and 11
  logic covActive, occActive, otcActive;
  logic cuvActive, ocdActive, otdActive;

  // ****************************************************************
  // detection
  // ****************************************************************
  logic [16:0] overchargeLimit;
  logic        cell_overvoltage, charge_overcurrent, charge_overheat;
  logic        cell_undervoltage, discharge_overcurrent, discharge_overheat;
  logic        chgOcRecovered, dsgOcRecovered;

  assign overchargeLimit = {1'b0, capacity_when_full}
                         + {1'b0, `OVERCHARGE_MARGIN_MAH};
  assign cell_overvoltage      = maxCellMv >= `CELL_OV_MV;
  assign charge_overcurrent    = chargeMa >= `CHG_OC_MA;
  assign charge_overheat       = chargeMode && tempC >= `CHG_OT_C;
  assign cell_undervoltage     = minCellMv <= `CELL_UV_MV;
  assign discharge_overcurrent = dischargeMa >= `DSG_OC_MA;
  assign discharge_overheat    = tempC >= `DSG_OT_C;

  hold_timer #(.CYCLES(OC_RECOVER_CYCLES)) chgOcTimer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .cond    (chargeMa <= `OC_RECOVER_MA),
    .expired (chgOcRecovered)
  );

  hold_timer #(.CYCLES(OC_RECOVER_CYCLES)) dsgOcTimer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .clkEn   (clkEn),
    .cond    (dischargeMa <= `OC_RECOVER_MA),
    .expired (dsgOcRecovered)
  );

  // ****************************************************************
  // overcharge alarm
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      overcharge_alarm <= 1'b0;
      dischargedSum    <= 17'h0;
    end else if (clkEn) begin
      if ({1'b0, capacity_left} > overchargeLimit) begin
        overcharge_alarm <= 1'b1;
        dischargedSum    <= 17'h0;
      end else if (overcharge_alarm) begin
        if (chargeMode) begin
          dischargedSum <= 17'h0;
        end else if (dischargedSum + {1'b0, dischargedMahDelta}
                     >= {1'b0, `OVERCHARGE_MARGIN_MAH}) begin
          overcharge_alarm <= 1'b0;
          dischargedSum    <= 17'h0;
        end else begin
          dischargedSum <= dischargedSum + {1'b0, dischargedMahDelta};
        end
      end
    end
  end

  // ****************************************************************
  // charge stop alarm, set beats clear
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      covActive <= 1'b0;
      occActive <= 1'b0;
      otcActive <= 1'b0;
      charge_stop_alarm <= 1'b0;
    end else if (clkEn) begin
      if (cell_overvoltage) covActive <= 1'b1;
      else if (maxCellMv <= `CELL_OV_RECOVER_MV) covActive <= 1'b0;
      if (charge_overcurrent) occActive <= 1'b1;
      else if (chgOcRecovered) occActive <= 1'b0;
      if (charge_overheat) otcActive <= 1'b1;
      else if (tempC <= `CHG_OT_RECOVER_C) otcActive <= 1'b0;
      if (chargeTermination || cell_overvoltage || charge_overcurrent
          || charge_overheat) begin
        charge_stop_alarm <= 1'b1;
      end else if (charge_percent <= `FULL_CLEAR_PCT
                   || (covActive && maxCellMv <= `CELL_OV_RECOVER_MV)
                   || (occActive && chgOcRecovered)
                   || (otcActive && tempC <= `CHG_OT_RECOVER_C)) begin
        charge_stop_alarm <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // over-temperature alarm
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      otCause <= battery_status_pkg::OT_NONE;
    end else if (clkEn) begin
      if (discharge_overheat && !chargeMode) begin
        otCause <= battery_status_pkg::OT_DISCHARGE;
      end else if (charge_overheat) begin
        otCause <= battery_status_pkg::OT_CHARGE;
      end else begin
        unique case (otCause)
          battery_status_pkg::OT_CHARGE: begin
            if (tempC <= `CHG_OT_RECOVER_C)
              otCause <= battery_status_pkg::OT_NONE;
          end
          battery_status_pkg::OT_DISCHARGE: begin
            if (tempC <= `DSG_OT_RECOVER_C)
              otCause <= battery_status_pkg::OT_NONE;
          end
          battery_status_pkg::OT_NONE: begin
          end
          default: otCause <= battery_status_pkg::OT_NONE;
        endcase
      end
    end
  end

  assign overTempAlarm      = otCause != battery_status_pkg::OT_NONE;
  assign chargeSwitchOff    = otCause == battery_status_pkg::OT_CHARGE;
  assign dischargeSwitchOff = otCause
                           == battery_status_pkg::OT_DISCHARGE;

  // ****************************************************************
  // discharge stop alarm
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cuvActive <= 1'b0;
      ocdActive <= 1'b0;
      otdActive <= 1'b0;
      discharge_stop_alarm <= 1'b0;
    end else if (clkEn) begin
      if (cell_undervoltage) cuvActive <= 1'b1;
      else if (minCellMv >= `CELL_UV_RECOVER_MV) cuvActive <= 1'b0;
      if (discharge_overcurrent) ocdActive <= 1'b1;
      else if (dsgOcRecovered) ocdActive <= 1'b0;
      if (discharge_overheat) otdActive <= 1'b1;
      else if (tempC <= `DSG_OT_RECOVER_C) otdActive <= 1'b0;
      if (charge_percent <= `EMPTY_SET_PCT || cell_undervoltage
          || discharge_overcurrent || discharge_overheat) begin
        discharge_stop_alarm <= 1'b1;
      end else if (charge_percent >= `DSG_CLEAR_PCT
                   || (cuvActive && minCellMv >= `CELL_UV_RECOVER_MV)
                   || (ocdActive && dsgOcRecovered)
                   || (otdActive && tempC <= `DSG_OT_RECOVER_C)) begin
        discharge_stop_alarm <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // user alarms and status flags
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      capAlarm         <= 1'b0;
      timeAlarm        <= 1'b0;
      discharging      <= 1'b1;
      gauge_ready_flag <= 1'b0;
    end else if (clkEn) begin
      capAlarm  <= capacity_threshold != 16'h0
                && capacity_left < capacity_threshold;
      timeAlarm <= runtime_threshold != 16'h0
                && runtime_left < runtime_threshold;
      discharging      <= !chargeMode;
      gauge_ready_flag <= gaugeInitDone;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      full_flag  <= 1'b0;
      empty_flag <= 1'b0;
    end else if (clkEn) begin
      if (chargeTermination) full_flag <= 1'b1;
      else if (charge_percent <= `FULL_CLEAR_PCT) full_flag <= 1'b0;
      if (charge_percent <= `EMPTY_SET_PCT) empty_flag <= 1'b1;
      else if (charge_percent >= `EMPTY_CLEAR_PCT) empty_flag <= 1'b0;
    end
  end

  // ****************************************************************
  // status word assembly, reserved bits zero
  // ****************************************************************
  always_comb begin
    pack_status_word = 16'h0;
    pack_status_word[`BIT_OVERCHARGE]     = overcharge_alarm;
    pack_status_word[`BIT_CHARGE_STOP]    = charge_stop_alarm;
    pack_status_word[`BIT_OVERTEMP]       = overTempAlarm;
    pack_status_word[`BIT_DISCHARGE_STOP] = discharge_stop_alarm;
    pack_status_word[`BIT_CAP_ALARM]      = capAlarm;
    pack_status_word[`BIT_TIME_ALARM]     = timeAlarm;
    pack_status_word[`BIT_GAUGE_READY]    = gauge_ready_flag;
    pack_status_word[`BIT_DISCHARGING]    = discharging;
    pack_status_word[`BIT_FULL]           = full_flag;
    pack_status_word[`BIT_EMPTY]          = empty_flag;
  end

  // ****************************************************************
  // read command answer
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      readValid <= 1'b0;
      readData  <= 16'h0;
    end else if (clkEn) begin
      readValid <= cmdRead;
      if (cmdRead) begin
        readData <= (cmdCode == `STATUS_WORD_CMD) ? pack_status_word
                                                   : 16'h0;
      end
    end
  end

  // ****************************************************************
  // critical alarm broadcast
  // ****************************************************************
  logic critical;
  assign critical     = (pack_status_word & `CRITICAL_MASK) != 16'h0;
  assign broadcastCmd = `ALARM_WORD_CMD;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      broadcastReq         <= 1'b0;
      broadcastTimer       <= 32'h0;
      alarm_broadcast_word <= 16'h0;
    end else if (clkEn) begin
      if (broadcastReq && broadcastAck) broadcastReq <= 1'b0;
      if (!critical) begin
        broadcastTimer <= 32'h0;
      end else if (broadcastTimer == 32'h0) begin
        broadcastReq         <= 1'b1;
        alarm_broadcast_word <= pack_status_word;
        broadcastTimer       <= 32'(BROADCAST_CYCLES - 1);
      end else begin
        broadcastTimer <= broadcastTimer - 32'h1;
      end
    end
  end
endmodule : battery_status_flag_logic
`default_nettype wire

// ---- battery_status_regs.svh ----
// register constants, thresholds and timing counts for the status word logic
`ifndef BATTERY_STATUS_REGS_SVH
`define BATTERY_STATUS_REGS_SVH

`define STATUS_WORD_CMD       8'h16
`define ALARM_WORD_CMD        8'h16
`define BIT_OVERCHARGE        15
`define BIT_CHARGE_STOP       14
`define BIT_OVERTEMP          12
`define BIT_DISCHARGE_STOP    11
`define BIT_CAP_ALARM         9
`define BIT_TIME_ALARM        8
`define BIT_GAUGE_READY       7
`define BIT_DISCHARGING       6
`define BIT_FULL              5
`define BIT_EMPTY             4
`define STATUS_RESET          16'h0040
`define CRITICAL_MASK         16'hd800

`define OVERCHARGE_MARGIN_MAH 16'h012c
`define CELL_OV_MV            16'h109a
`define CELL_OV_RECOVER_MV    16'h1036
`define CELL_UV_MV            16'h09c4
`define CELL_UV_RECOVER_MV    16'h0bb8
`define CHG_OC_MA             16'h07d0
`define DSG_OC_MA             16'h109a
`define OC_RECOVER_MA         16'h00c8
`define CHG_OT_C              8'h3a
`define CHG_OT_RECOVER_C      8'h37
`define DSG_OT_C              8'h4b
`define DSG_OT_RECOVER_C      8'h41
`define FULL_CLEAR_PCT        8'h5f
`define EMPTY_CLEAR_PCT       8'h14
`define EMPTY_SET_PCT         8'h00
`define DSG_CLEAR_PCT         8'h01

`define CLK_HZ                10000000
`define OC_RECOVER_SEC        70
`define BROADCAST_SEC         10
`define OC_RECOVER_CYCLES     (`OC_RECOVER_SEC * `CLK_HZ)
`define BROADCAST_CYCLES      (`BROADCAST_SEC * `CLK_HZ)

`endif

// ---- battery_status_pkg.sv ----
// types for the pack status word logic
`default_nettype none
package battery_status_pkg;
  typedef logic [15:0] word_type;
  typedef enum logic [1:0] {
    OT_NONE,
    OT_CHARGE,
    OT_DISCHARGE
  } overtemp_type;
endpackage : battery_status_pkg
`default_nettype wire

// ---- hold_timer.sv ----
// counts how long a condition has held continuously
`default_nettype none
module hold_timer #(
  parameter int unsigned CYCLES = 700000000
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic clkEn,
  // condition and result
  input  wire logic cond,
  output logic      expired
);
  logic [31:0] count;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      count   <= 32'h0;
      expired <= 1'b0;
    end else if (clkEn) begin
      if (!cond) begin
        count   <= 32'h0;
        expired <= 1'b0;
      end else if (count >= 32'(CYCLES - 1)) begin
        expired <= 1'b1;
      end else begin
        count <= count + 32'h1;
      end
    end
  end
endmodule : hold_timer
`default_nettype wire

// ---- status_word_chk.sv ----
// checker for the pack status word logic
`default_nettype none
module status_word_chk #(
  parameter int unsigned OC_RECOVER_CYCLES = 20,
  parameter int unsigned BROADCAST_CYCLES  = 50
) (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  input wire logic        clkEn,
  // gauge quantities
  input wire logic [15:0] capacity_left,
  input wire logic [15:0] capacity_when_full,
  input wire logic [7:0]  charge_percent,
  input wire logic [15:0] capacity_threshold,
  input wire logic [15:0] runtime_left,
  input wire logic [15:0] runtime_threshold,
  input wire logic [15:0] maxCellMv,
  input wire logic [15:0] chargeMa,
  input wire logic        chargeMode,
  input wire logic        chargeTermination,
  input wire logic        gaugeInitDone,
  // bus side and switches
  input wire logic        cmdRead,
  input wire logic [7:0]  cmdCode,
  input wire logic        readValid,
  input wire logic [15:0] readData,
  input wire logic        broadcastReq,
  input wire logic        broadcastAck,
  input wire logic [7:0]  broadcastCmd,
  input wire logic        chargeSwitchOff,
  input wire logic        dischargeSwitchOff,
  input wire battery_status_pkg::word_type pack_status_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // helper terms and properties
  // ********************************
  logic capLow, timeLow, crit, overFull;
  assign capLow = capacity_threshold != 16'h0 &&
                  capacity_left < capacity_threshold;
  assign timeLow = runtime_threshold != 16'h0 &&
                   runtime_left < runtime_threshold;
  assign crit = (pack_status_word & 16'hd800) != 16'h0;
  assign overFull = {1'b0, capacity_left} >
                    ({1'b0, capacity_when_full} + 17'h0012c);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence reqHeld;
    broadcastReq && !broadcastAck;
  endsequence
  sequence reqTaken;
    broadcastReq && broadcastAck && clkEn;
  endsequence
  chk_read_pulse: assert property (
    clkEn |=> readValid == $past(cmdRead))
    else $error("read answer pulse wrong");
  chk_read_data: assert property (clkEn && cmdRead |=> readData ==
    ($past(cmdCode) == 8'h16 ? $past(pack_status_word) : 16'h0000))
    else $error("read data wrong");
  chk_reserved_zero: assert property (
    (pack_status_word & 16'h240f) == 0)
    else $error("reserved bits not zero");
  chk_ready_flag: assert property (
    clkEn |=> pack_status_word[7] == $past(gaugeInitDone))
    else $error("ready flag wrong");
  chk_dsg_flag: assert property (
    clkEn |=> pack_status_word[6] == !$past(chargeMode))
    else $error("discharging flag wrong");
  chk_cap_alarm: assert property (
    clkEn |=> pack_status_word[9] == $past(capLow))
    else $error("capacity alarm wrong");
  chk_time_alarm: assert property (
    clkEn |=> pack_status_word[8] == $past(timeLow))
    else $error("runtime alarm wrong");
  chk_overcharge_set: assert property (
    clkEn && overFull |=> pack_status_word[15])
    else $error("overcharge alarm not set");
  chk_chg_stop_set: assert property (clkEn && (maxCellMv >= 16'h109a ||
    chargeMa >= 16'h07d0 || chargeTermination) |=> pack_status_word[14])
    else $error("charge stop alarm not set");
  chk_empty_set: assert property (clkEn && charge_percent == 8'h00
    |=> pack_status_word[11] && pack_status_word[4])
    else $error("empty flags not set");
  chk_switch_off: assert property (
    pack_status_word[12] |-> chargeSwitchOff || dischargeSwitchOff)
    else $error("switch left on in overheat");
  chk_req_stands: assert property (reqHeld |=> broadcastReq)
    else $error("broadcast request dropped early");
  chk_req_release: assert property (reqTaken |=> !broadcastReq)
    else $error("broadcast request not released");
  chk_req_cause: assert property ($rose(broadcastReq) |->
    $past(crit) && broadcastCmd == 8'h16)
    else $error("broadcast without critical alarm");
endmodule : status_word_chk
bind battery_status_flag_logic status_word_chk #(
  .OC_RECOVER_CYCLES(OC_RECOVER_CYCLES), .BROADCAST_CYCLES(BROADCAST_CYCLES)
) u_chk (
  .sys_clk, .rst_b, .clkEn, .capacity_left, .capacity_when_full,
  .charge_percent, .capacity_threshold, .runtime_left, .runtime_threshold,
  .maxCellMv, .chargeMa, .chargeMode, .chargeTermination, .gaugeInitDone,
  .cmdRead, .cmdCode, .readValid, .readData, .broadcastReq, .broadcastAck,
  .broadcastCmd, .chargeSwitchOff, .dischargeSwitchOff, .pack_status_word
);
`default_nettype wire

// ---- host_model.sv ----
// host and charger model: acknowledges alarm broadcasts
`default_nettype none
module host_model (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        rst_b,
  // bus side
  input wire logic        broadcastReq,
  input wire logic [15:0] pack_status_word,
  input wire logic [3:0]  ackDelay,
  output logic            broadcastAck,
  // charger and load control
  output logic            stopCharge,
  output logic            stopLoad
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // acknowledge after a set delay
  // ********************************
  logic [3:0] waitCnt;
  assign stopCharge = pack_status_word[15] | pack_status_word[14];
  assign stopLoad = pack_status_word[11];
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt <= 4'h0;
      broadcastAck <= 1'b0;
    end else if (broadcastReq && !broadcastAck) begin
      if (waitCnt >= ackDelay) broadcastAck <= 1'b1;
      else waitCnt <= waitCnt + 4'h1;
    end else if (!broadcastReq) begin
      broadcastAck <= 1'b0;
      waitCnt <= 4'h0;
    end
  end
endmodule : host_model
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the pack status word logic
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************************
  // stimulus, expectations, verdict
  // ********************************
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic chargeMode, chargeTermination, gaugeInitDone, cmdRead, readValid;
  logic broadcastReq, broadcastAck, chargeSwitchOff, dischargeSwitchOff;
  logic stopCharge;
  logic [3:0] ackDelay;
  logic [7:0] charge_percent, cmdCode, tempC, broadcastCmd;
  logic [15:0] capacity_left, capacity_when_full, capacity_threshold;
  logic [15:0] runtime_left, runtime_threshold, maxCellMv, minCellMv;
  logic [15:0] chargeMa, dischargeMa, dischargedMahDelta, readData, d;
  battery_status_pkg::word_type alarm_broadcast_word, pack_status_word;
  int nFail = 0;
  int cmpCount = 0;
  int seed = 32'h78b186d8;
  int i, w;
  // sel, value, mask, expected bits
  localparam int TBL[35][4] = '{
    '{6, 16'h0001, 16'h0040, 16'h0000}, '{5, 16'h0062, 16'h4000, 16'h0000},
    '{0, 16'h109a, 16'h4000, 16'h4000}, '{0, 16'h1037, 16'h4000, 16'h4000},
    '{0, 16'h1036, 16'h4000, 16'h0000}, '{2, 16'h07d0, 16'h4000, 16'h4000},
    '{2, 16'h0064, 16'h4000, 16'h4000}, '{8, 16'h0019, 16'h4000, 16'h0000},
    '{4, 16'h003a, 16'h5000, 16'h5000}, '{4, 16'h0038, 16'h5000, 16'h5000},
    '{4, 16'h0037, 16'h5000, 16'h0000}, '{7, 16'h0001, 16'h4020, 16'h4020},
    '{7, 16'h0000, 16'h4020, 16'h4020}, '{5, 16'h0060, 16'h4020, 16'h4020},
    '{5, 16'h005f, 16'h4020, 16'h0000}, '{6, 16'h0000, 16'h0040, 16'h0040},
    '{4, 16'h004b, 16'h1800, 16'h1800}, '{4, 16'h0042, 16'h1800, 16'h1000},
    '{4, 16'h0041, 16'h1800, 16'h0000}, '{5, 16'h0000, 16'h0810, 16'h0810},
    '{5, 16'h0001, 16'h0810, 16'h0010}, '{5, 16'h0013, 16'h0810, 16'h0010},
    '{5, 16'h0014, 16'h0810, 16'h0000}, '{1, 16'h09c4, 16'h0800, 16'h0800},
    '{1, 16'h0bb7, 16'h0800, 16'h0000}, '{1, 16'h0bb8, 16'h0800, 16'h0000},
    '{3, 16'h109a, 16'h0800, 16'h0800}, '{3, 16'h0064, 16'h0800, 16'h0000},
    '{8, 16'h0019, 16'h0800, 16'h0000}, '{9, 16'h08fc, 16'h8000, 16'h0000},
    '{9, 16'h08fd, 16'h8000, 16'h8000}, '{9, 16'h03e8, 16'h8000, 16'h8000},
    '{10, 16'h0096, 16'h8000, 16'h8000}, '{10, 16'h0095, 16'h8000, 16'h8000},
    '{10, 16'h0001, 16'h8000, 16'h0000}};
  always #50 sys_clk = ~sys_clk;
  battery_status_flag_logic #(.OC_RECOVER_CYCLES(20), .BROADCAST_CYCLES(50))
  DUT (
    .sys_clk, .rst_b, .clkEn, .capacity_left, .capacity_when_full,
    .charge_percent, .capacity_threshold, .runtime_left, .runtime_threshold,
    .maxCellMv, .minCellMv, .chargeMa, .dischargeMa, .dischargedMahDelta,
    .tempC, .chargeMode, .chargeTermination, .gaugeInitDone, .cmdRead,
    .cmdCode, .readValid, .readData, .broadcastReq, .broadcastAck,
    .broadcastCmd, .alarm_broadcast_word, .chargeSwitchOff,
    .dischargeSwitchOff, .pack_status_word);
  host_model HOST (.sys_clk, .rst_b, .broadcastReq, .pack_status_word,
    .ackDelay, .broadcastAck, .stopCharge, .stopLoad());
  function automatic logic alarmBit(input logic [15:0] thr, val);
    return thr != 16'h0 && val < thr;
  endfunction : alarmBit
  function automatic logic [15:0] pick(input logic [15:0] v);
    case (($random(seed) & 3))
      0: return 16'h0000;
      1: return v;
      2: return v + 16'h0001;
      default: return 16'($random(seed));
    endcase
  endfunction : pick
  task automatic check16(input logic [15:0] got, exp, input string what);
    cmpCount++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check16
  task automatic readWord(input logic [7:0] code);
    @(posedge sys_clk);
    #5 cmdRead = 1'b1;
    cmdCode = code;
    @(posedge sys_clk);
    #5 cmdRead = 1'b0;
    check16({15'h0, readValid}, 16'h0001, "read answer");
    d = readData;
  endtask : readWord
  task automatic applyStep(input int sel, input logic [15:0] v);
    @(posedge sys_clk);
    #5;
    case (sel)
      0: maxCellMv = v;
      1: minCellMv = v;
      2: chargeMa = v;
      3: dischargeMa = v;
      4: tempC = v[7:0];
      5: charge_percent = v[7:0];
      6: chargeMode = v[0];
      7: chargeTermination = v[0];
      8: repeat (v) @(posedge sys_clk);
      9: capacity_left = v;
      default: begin
        dischargedMahDelta = v;
        @(posedge sys_clk);
        #5 dischargedMahDelta = 16'h0000;
      end
    endcase
    repeat (2) @(posedge sys_clk);
  endtask : applyStep
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  initial begin
    #2000000;
    nFail++;
    $display("ERROR %0t watchdog expired", $time);
    give_verdict();
  end
  initial begin
    {chargeMode, chargeTermination, gaugeInitDone, cmdRead} = 4'h0;
    {cmdCode, ackDelay, chargeMa, dischargeMa, dischargedMahDelta} = '0;
    {capacity_threshold, runtime_threshold} = '0;
    capacity_left = 16'h03e8;
    capacity_when_full = 16'h07d0;
    runtime_left = 16'h0064;
    charge_percent = 8'h32;
    maxCellMv = 16'h0e74;
    minCellMv = 16'h0e10;
    tempC = 8'h19;
    repeat (16) @(posedge sys_clk);
    #5 rst_b = 1'b1;
    readWord(8'h16);
    check16(d, 16'h0040, "reset word");
    clkEn = 1'b0;
    gaugeInitDone = 1'b1;
    repeat (3) @(posedge sys_clk);
    #5 check16(pack_status_word, 16'h0040, "enable low");
    clkEn = 1'b1;
    readWord(8'h17);
    check16(d, 16'h0000, "unmapped code");
    readWord(8'h16);
    check16(d, 16'h00c0, "ready word");
    for (i = 0; i < 35; i++) begin
      ackDelay = 4'(i % 7);
      applyStep(TBL[i][0], 16'(TBL[i][1]));
      readWord(8'h16);
      check16(d & 16'(TBL[i][2]), 16'(TBL[i][3]),
              "status");
      check16({14'h0, chargeSwitchOff, dischargeSwitchOff}, {14'h0,
              1'(i == 8 || i == 9), 1'(i == 16 || i == 17)}, "switch");
      if (i == 30) begin
        for (w = 0; w < 80 && broadcastReq !== 1'b1; w++) #100;
        check16({15'h0, broadcastReq}, 16'h0001, "broadcast request");
        check16(alarm_broadcast_word & 16'hd800, 16'h8000, "broadcast");
      end
    end
    for (i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #5 capacity_left = 16'($random(seed)) & 16'h07ff;
      runtime_left = 16'($random(seed)) & 16'h07ff;
      capacity_threshold = pick(capacity_left);
      runtime_threshold = pick(runtime_left);
      chargeMode = 1'($random(seed)) & !stopCharge;
      repeat (2) @(posedge sys_clk);
      readWord(8'h16);
      check16(d & 16'h0340,
              {6'h0, alarmBit(capacity_threshold, capacity_left),
               alarmBit(runtime_threshold, runtime_left), 1'b0,
               !chargeMode, 6'h0}, "alarms");
    end
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
